// ==== include/tdm_switch_pkg.sv ====
`default_nettype none
package tdm_switch_pkg;
  // ==================================================
  // access commands
  localparam logic [7:0] CMD_TRI_ONE = 8'h60;
  localparam logic [7:0] CMD_TRI_ALL = 8'h68;
  localparam logic [7:0] CMD_CODE_0 = 8'h70;
  localparam logic [7:0] CMD_CONN = 8'h71;
  localparam logic [7:0] CMD_CODE_8 = 8'h78;
  localparam logic [7:0] CMD_DATA_A = 8'h7a;
  localparam logic [7:0] CMD_CODE_B = 8'h7b;
  localparam logic [7:0] CM_FILL = 8'hff;
  // ==================================================
  // operation mode fields
  localparam int OMS_HI = 7;
  localparam int OMS_LO = 6;
  localparam int STANDBY_BIT = 5;
  localparam logic [7:0] MODE_RESET_VAL = 8'h00;
  // ==================================================
  // status layout
  localparam int BUSY_BIT = 2;
  localparam int SYNC_BIT = 5;
  localparam int MONITOR_FIFO_BIT = 2;
  localparam int NORMAL_BIT = 0;
  localparam int PFI_BIT = 3;
  localparam int TOP_SW_BIT = 5;
  // ==================================================
  // timing in switch reference clock cycles
  localparam logic [10:0] FILL_CYCLES = 11'd1035;
  localparam logic [10:0] CMD_CYCLES = 11'd2;
  localparam int CI_HI = 5;
  localparam int CI_LO = 2;
  typedef enum logic [1:0] {
    CM_RESET = 2'b00,
    CM_INIT = 2'b01,
    CM_NORMAL = 2'b11
  } cm_mode_t;
endpackage
`default_nettype wire

// ==== hw/tdm_switch_memory_access.sv ====
`default_nettype none
module tdm_switch_memory_access (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // access command registers
  input wire logic i_acr_wr,
  input wire logic [7:0] i_access_control_reg,
  input wire logic [7:0] i_access_address_reg,
  input wire logic [7:0] i_access_data_reg,
  // mode and configuration
  input wire logic i_mode_wr,
  input wire logic [7:0] i_operation_mode_reg,
  input wire logic [7:0] i_trunk_bit_number_reg,
  input wire logic [7:0] i_subscriber_bit_number_reg,
  input wire logic [7:0] i_subchannel_reg,
  // trunk pins and monitor state
  input wire logic i_trunk_sync,
  input wire logic i_monitor_fifo_ready,
  input wire logic i_sw_int_ack,
  // slot timing and command/indication
  input wire logic [7:0] i_trunk_slot,
  input wire logic [7:0] i_ci_up_slot,
  input wire logic [3:0] i_ci_rx,
  input wire logic [7:0] i_ci_dn_slot,
  // status
  output logic o_access_busy_flag,
  output logic [7:0] o_switch_status_reg,
  output logic [7:0] o_switch_status_value,
  output logic [7:0] o_top_interrupt_status,
  output logic [7:0] o_switch_interrupt_status,
  output logic o_irq,
  // switching outputs
  output logic [3:0] o_trunk_drive,
  output logic [3:0] o_ci_tx,
  output logic o_ci_match,
  output logic [9:0] o_trunk_frame_bits,
  output logic [9:0] o_sub_frame_bits,
  output logic [11:0] o_subch_msb
);
  // ==================================================
  // storage and state
  logic [7:0] cm_data [256];
  logic [3:0] cm_code [256];
  logic [7:0] tri_field [256];
  logic [10:0] busy_cnt;
  logic [7:0] mode_reg;
  tdm_switch_pkg::cm_mode_t mode;
  logic sync_a, sync_b, mf_a, mf_b, sync_q;
  logic trunk_framing_change_event;
  logic was_normal;
  logic accept;
  logic is_tri, is_cm;
  logic [3:0] next_code;
  logic data_wr;

  // commands arriving while busy are dropped; the host must poll first
  assign accept = i_acr_wr && (busy_cnt == 11'd0);
  assign is_tri = (i_access_control_reg == tdm_switch_pkg::CMD_TRI_ONE) ||
                  (i_access_control_reg == tdm_switch_pkg::CMD_TRI_ALL);
  assign is_cm = (i_access_control_reg[7:4] == 4'h7);
  assign next_code = i_access_control_reg[3:0];
  // only 71 and 7A carry data; the others touch the code alone, except 70 with FF in reset mode, which fills every entry
  assign data_wr = (i_access_control_reg == tdm_switch_pkg::CMD_CONN) ||
                   (i_access_control_reg == tdm_switch_pkg::CMD_DATA_A);

  function automatic tdm_switch_pkg::cm_mode_t decode_mode(input logic [1:0] oms);
    case (oms)
      2'b10: decode_mode = tdm_switch_pkg::CM_INIT;
      2'b11: decode_mode = tdm_switch_pkg::CM_NORMAL;
      default: decode_mode = tdm_switch_pkg::CM_RESET;
    endcase
  endfunction

  // ==================================================
  // pin synchronisers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      mf_a <= 1'b0;
      mf_b <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      sync_a <= i_trunk_sync;
      sync_b <= sync_a;
      mf_a <= i_monitor_fifo_ready;
      mf_b <= mf_a;
      sync_q <= sync_b;
    end
  end

  // ==================================================
  // operation mode
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_reg <= tdm_switch_pkg::MODE_RESET_VAL;
      mode <= tdm_switch_pkg::CM_RESET;
    end else if (i_mode_wr) begin
      mode_reg <= i_operation_mode_reg;
      mode <= decode_mode(i_operation_mode_reg[tdm_switch_pkg::OMS_HI:tdm_switch_pkg::OMS_LO]);
    end
  end

  // ==================================================
  // busy counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_cnt <= 11'd0;
    end else if (accept && (is_tri || is_cm)) begin
      busy_cnt <= (i_access_control_reg == tdm_switch_pkg::CMD_TRI_ALL) ?
                  tdm_switch_pkg::FILL_CYCLES : tdm_switch_pkg::CMD_CYCLES;
    end else if (busy_cnt != 11'd0) begin
      busy_cnt <= busy_cnt - 11'd1;
    end
  end

  // ==================================================
  // control memory
  always_ff @(posedge i_clk) begin
    if (accept && is_cm) begin
      if ((mode == tdm_switch_pkg::CM_RESET) &&
          (i_access_control_reg == tdm_switch_pkg::CMD_CODE_0) &&
          (i_access_data_reg == tdm_switch_pkg::CM_FILL)) begin
        for (int i = 0; i < 256; i++) begin
          cm_data[i] <= tdm_switch_pkg::CM_FILL;
          cm_code[i] <= 4'hf;
        end
      end else begin
        cm_code[i_access_address_reg] <= next_code;
        if (data_wr) begin
          cm_data[i_access_address_reg] <= i_access_data_reg;
        end
      end
    end
  end

  // ==================================================
  // tristate field
  always_ff @(posedge i_clk) begin
    if (accept && (i_access_control_reg == tdm_switch_pkg::CMD_TRI_ALL)) begin
      for (int i = 0; i < 256; i++) begin
        tri_field[i] <= i_access_data_reg;
      end
    end else if (accept && (i_access_control_reg == tdm_switch_pkg::CMD_TRI_ONE)) begin
      tri_field[i_access_address_reg] <= i_access_data_reg;
    end
  end

  // ==================================================
  // framing-change interrupt
  // one-cycle history of the mode, so entering normal mode is seen as an edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      was_normal <= 1'b0;
    end else begin
      was_normal <= (mode == tdm_switch_pkg::CM_NORMAL);
    end
  end

  // set beats acknowledge so an event in the clearing cycle survives
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      trunk_framing_change_event <= 1'b0;
    end else if (mode == tdm_switch_pkg::CM_NORMAL &&
                 (!was_normal || sync_b != sync_q)) begin
      trunk_framing_change_event <= 1'b1;
    end else if (i_sw_int_ack) begin
      trunk_framing_change_event <= 1'b0;
    end
  end

  // ==================================================
  // outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_switch_status_value <= 8'h00;
      o_trunk_drive <= 4'h0;
      o_ci_tx <= 4'h0;
      o_ci_match <= 1'b0;
      o_trunk_frame_bits <= 10'h000;
      o_sub_frame_bits <= 10'h000;
      o_subch_msb <= 12'h000;
    end else begin
      o_switch_status_value <= 8'h00;
      o_switch_status_value[tdm_switch_pkg::SYNC_BIT] <= sync_b;
      o_switch_status_value[tdm_switch_pkg::MONITOR_FIFO_BIT] <= mf_b;
      o_switch_status_value[tdm_switch_pkg::NORMAL_BIT] <=
        (mode == tdm_switch_pkg::CM_NORMAL);
      o_trunk_drive <= mode_reg[tdm_switch_pkg::STANDBY_BIT] ?
                       tri_field[i_trunk_slot][3:0] : 4'h0;
      o_ci_tx <= cm_data[i_ci_dn_slot][tdm_switch_pkg::CI_HI:tdm_switch_pkg::CI_LO];
      o_ci_match <= (i_ci_rx ==
        cm_data[i_ci_up_slot][tdm_switch_pkg::CI_HI:tdm_switch_pkg::CI_LO]);
      o_trunk_frame_bits <= {1'b0, i_trunk_bit_number_reg, 1'b0} + 10'd2;
      o_sub_frame_bits <= {2'b00, i_subscriber_bit_number_reg} + 10'd1;
      for (int p = 0; p < 4; p++) begin
        o_subch_msb[p*3 +: 3] <= 3'd7 - {i_subchannel_reg[p*2 +: 2], 1'b0};
      end
    end
  end

  assign o_access_busy_flag = (busy_cnt != 11'd0);
  assign o_switch_status_reg = {5'h00, o_access_busy_flag, 2'b00};
  assign o_switch_interrupt_status = {4'h0, trunk_framing_change_event, 3'h0};
  assign o_top_interrupt_status = {2'b00, trunk_framing_change_event, 5'h00};
  assign o_irq = trunk_framing_change_event;

  // ==================================================
  // assertions
  localparam int FILL_LEN = 1035;
  logic [10:0] busy_len;
  logic last_fill;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_len <= 11'd0;
      last_fill <= 1'b0;
    end else if (accept && (is_tri || is_cm)) begin
      busy_len <= 11'd1;
      last_fill <= (i_access_control_reg == tdm_switch_pkg::CMD_TRI_ALL);
    end else if (busy_cnt > 11'd1) begin
      // the first busy cycle is already counted, so busy_len equals the busy length
      busy_len <= busy_len + 11'd1;
    end
  end

  sequence s_conn_cmd;
    accept && i_access_control_reg == tdm_switch_pkg::CMD_CONN;
  endsequence

  a_busy_after_cmd: assert property (@(posedge i_clk) disable iff (i_rst)
    accept && (is_tri || is_cm) |=> o_access_busy_flag[*2] ##1 !o_access_busy_flag || last_fill)
    else $error("busy flag wrong after command");
  a_fill_length: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_access_busy_flag) && last_fill |-> busy_len == FILL_LEN[10:0])
    else $error("tristate fill not 1035 cycles");
  a_conn_write: assert property (@(posedge i_clk) disable iff (i_rst)
    s_conn_cmd |=> cm_code[$past(i_access_address_reg)] == 4'h1 &&
      cm_data[$past(i_access_address_reg)] == $past(i_access_data_reg))
    else $error("connection write wrong");
  a_cm_reset_all: assert property (@(posedge i_clk) disable iff (i_rst)
    accept && mode == tdm_switch_pkg::CM_RESET && i_access_control_reg == 8'h70 &&
      i_access_data_reg == 8'hff |=> cm_data[0] == 8'hff && cm_data[255] == 8'hff)
    else $error("control memory reset incomplete");
  a_mode_init: assert property (@(posedge i_clk) disable iff (i_rst)
    i_mode_wr && i_operation_mode_reg == 8'h80 |=> mode == tdm_switch_pkg::CM_INIT)
    else $error("mode 80 did not enter init");
  a_normal_irq: assert property (@(posedge i_clk) disable iff (i_rst)
    i_mode_wr && i_operation_mode_reg == 8'hc0 && mode != tdm_switch_pkg::CM_NORMAL
      |=> ##1 o_irq && o_top_interrupt_status == 8'h20 && o_switch_interrupt_status == 8'h08)
    else $error("normal mode interrupt missing");
  a_tri_single: assert property (@(posedge i_clk) disable iff (i_rst)
    accept && i_access_control_reg == 8'h60 |=>
      tri_field[$past(i_access_address_reg)] == $past(i_access_data_reg))
    else $error("single tristate update wrong");
  a_standby_hiz: assert property (@(posedge i_clk) disable iff (i_rst)
    !mode_reg[tdm_switch_pkg::STANDBY_BIT] && $stable(mode_reg) |=> o_trunk_drive == 4'h0)
    else $error("drivers on in standby");
  a_ci_code_only: assert property (@(posedge i_clk) disable iff (i_rst)
    accept && i_access_control_reg == 8'h78 |=>
      cm_code[$past(i_access_address_reg)] == 4'h8 &&
      cm_data[$past(i_access_address_reg)] == $past(cm_data[i_access_address_reg]))
    else $error("code-only command changed data");
endmodule
`default_nettype wire

// ==== tb/tdm_host_model.sv ====
`default_nettype none
module tdm_host_model (
  // clock and status from the switch
  input wire logic i_clk,
  input wire logic i_access_busy_flag,
  // register writes towards the switch
  output logic o_acr_wr,
  output logic [7:0] o_access_control_reg,
  output logic [7:0] o_access_address_reg,
  output logic [7:0] o_access_data_reg,
  output logic o_mode_wr,
  output logic [7:0] o_operation_mode_reg
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_acr_wr = 1'b0;
    o_access_control_reg = 8'h00;
    o_access_address_reg = 8'h00;
    o_access_data_reg = 8'h00;
    o_mode_wr = 1'b0;
    o_operation_mode_reg = 8'h00;
  end
  // ==================================================
  // one command; gap idles first, again rewrites while busy on purpose
  task automatic cmd(input logic [7:0] c, a, d, input int gap, input bit again,
                     output int n);
    n = 0;
    while (i_access_busy_flag !== 1'b0) begin
      @(posedge i_clk);
      #1;
    end
    repeat (gap) begin
      @(posedge i_clk);
      #1;
    end
    o_access_control_reg = c;
    o_access_address_reg = a;
    o_access_data_reg = d;
    o_acr_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_acr_wr = again;
    if (again) o_access_data_reg = ~d;
    while (i_access_busy_flag === 1'b1) begin
      n++;
      @(posedge i_clk);
      #1;
      o_acr_wr = 1'b0;
    end
  endtask
  task automatic mode(input logic [7:0] m);
    o_operation_mode_reg = m;
    o_mode_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_mode_wr = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/tdm_switch_memory_access_test.sv ====
`default_nettype none
module tdm_switch_memory_access_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int sel; logic [11:0] val;} note_t;
  note_t notes[$];
  note_t cur;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  logic [31:0] seed = 32'h925c;
  logic [31:0] r;
  logic [11:0] sb;
  logic [7:0] codes [3] = '{8'h78, 8'h7b, 8'h70};
  logic i_clk, i_rst, acr_wr, mode_wr, sync, monitor_fifo, ack, busy, irq, ci_match;
  logic [7:0] ctl, addr, data, omode, tbn, sbn, subch, tslot, upslot, dnslot;
  logic [7:0] switch_status_reg, stare, top_is, sw_is;
  logic [3:0] ci_rx, drive, ci_tx;
  logic [9:0] tfb, sfb;
  logic [11:0] subch_msb;
  function automatic logic [11:0] observe(input int s);
    case (s)
      0: return 12'(tfb);
      1: return 12'(sfb);
      2: return subch_msb;
      3: return 12'(ci_tx);
      4: return 12'(ci_match);
      5: return 12'(irq);
      6: return 12'(top_is);
      7: return 12'(sw_is);
      8: return 12'(stare);
      default: return 12'(drive);
    endcase
  endfunction
  // ==================================================
  // design and host
  tdm_switch_memory_access i_tdm_switch_memory_access (.i_clk(i_clk), .i_rst(i_rst),
    .i_acr_wr(acr_wr), .i_access_control_reg(ctl), .i_access_address_reg(addr),
    .i_access_data_reg(data), .i_mode_wr(mode_wr), .i_operation_mode_reg(omode),
    .i_trunk_bit_number_reg(tbn), .i_subscriber_bit_number_reg(sbn),
    .i_subchannel_reg(subch), .i_trunk_sync(sync), .i_monitor_fifo_ready(monitor_fifo),
    .i_sw_int_ack(ack), .i_trunk_slot(tslot), .i_ci_up_slot(upslot), .i_ci_rx(ci_rx),
    .i_ci_dn_slot(dnslot), .o_access_busy_flag(busy), .o_switch_status_reg(switch_status_reg),
    .o_switch_status_value(stare), .o_top_interrupt_status(top_is),
    .o_switch_interrupt_status(sw_is), .o_irq(irq), .o_trunk_drive(drive),
    .o_ci_tx(ci_tx), .o_ci_match(ci_match), .o_trunk_frame_bits(tfb),
    .o_sub_frame_bits(sfb), .o_subch_msb(subch_msb));
  tdm_host_model i_tdm_host_model (.i_clk(i_clk), .i_access_busy_flag(busy),
    .o_acr_wr(acr_wr), .o_access_control_reg(ctl), .o_access_address_reg(addr),
    .o_access_data_reg(data), .o_mode_wr(mode_wr), .o_operation_mode_reg(omode));
  // ==================================================
  // helpers
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic want(input int s, input logic [11:0] v);
    notes.push_back('{s, v});
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // outputs are read before this edge's updates land, so notes see settled values
  always @(posedge i_clk) begin
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      check(observe(cur.sel), cur.val);
    end
    // the status register must carry the busy flag at bit 2 and nothing else
    check(12'(switch_status_reg), 12'(busy) << 2);
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      test_done();
    end
  end
  // ==================================================
  // scenarios
  initial begin
    {i_rst, sync, monitor_fifo, ack} = 4'b1110;
    {tbn, sbn, subch, tslot, upslot, dnslot} = '0;
    ci_rx = 4'h0;
    repeat (8) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    tbn = 8'hff;
    sbn = 8'hff;
    tick(2);
    want(0, 12'd512);
    want(1, 12'd256);
    want(2, 12'hfff);
    r = rnd();
    {subch, sbn, tbn} = r[23:0];
    for (int p = 0; p < 4; p++) sb[p*3 +: 3] = 3'd7 - {r[16+2*p +: 2], 1'b0};
    tick(2);
    want(0, (12'(r[7:0]) + 12'd1) << 1);
    want(1, 12'(r[15:8]) + 12'd1);
    want(2, sb);
    dnslot = r[31:24];
    i_tdm_host_model.cmd(8'h70, 8'h00, 8'hff, 0, 1'b0, n);
    check(12'(n), 12'(tdm_switch_pkg::CMD_CYCLES));
    tick(2);
    want(3, 12'hf);
    i_tdm_host_model.mode(8'h80);
    i_tdm_host_model.cmd(8'h71, 8'h80, 8'h89, 2, 1'b0, n);
    dnslot = 8'h80;
    tick(2);
    want(3, 12'h2);
    // second write lands while busy and must be dropped
    i_tdm_host_model.cmd(8'h7a, 8'h08, 8'hf3, 0, 1'b1, n);
    dnslot = 8'h08;
    tick(2);
    want(3, 12'hc);
    foreach (codes[i]) begin
      i_tdm_host_model.cmd(codes[i], 8'h08, 8'h00, i, 1'b0, n);
      check(12'(n), 12'(tdm_switch_pkg::CMD_CYCLES));
      tick(2);
      want(3, 12'hc);
    end
    i_tdm_host_model.cmd(8'h71, 8'h88, 8'hff, 1, 1'b0, n);
    upslot = 8'h88;
    ci_rx = 4'hf;
    tick(2);
    want(4, 12'h1);
    ci_rx = {1'b0, r[2:0]};
    tick(2);
    want(4, 12'h0);
    i_tdm_host_model.mode(8'hc0);
    tick(4);
    want(5, 12'h1);
    want(6, 12'h20);
    want(7, 12'h08);
    want(8, 12'h25);
    ack = 1'b1;
    tick(1);
    ack = 1'b0;
    tick(1);
    want(5, 12'h0);
    i_tdm_host_model.mode(8'he0);
    i_tdm_host_model.cmd(8'h68, 8'h00, 8'h00, 0, 1'b0, n);
    check(12'(n), 12'(tdm_switch_pkg::FILL_CYCLES));
    tslot = r[15:8];
    tick(2);
    want(9, 12'h0);
    i_tdm_host_model.cmd(8'h60, 8'h89, 8'h0f, 3, 1'b0, n);
    tslot = 8'h89;
    tick(2);
    want(9, 12'hf);
    tslot = 8'h88;
    tick(2);
    want(9, 12'h0);
    tslot = 8'h89;
    i_tdm_host_model.mode(8'hc0);
    tick(2);
    want(9, 12'h0);
    tick(2);
    test_done();
  end
endmodule
`default_nettype wire
